// ==== core/ssr_status_log.v ====
`include "ssr_map.vh"
// status log page responder, sits behind the taskfile
module ssr_status_log (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        tf_we,
  input  wire [2:0]  tf_addr,
  input  wire [7:0]  tf_wdata,
  output reg  [7:0]  tf_status,
  output reg  [7:0]  tf_error,
  output reg  [15:0] rd_word,
  output reg         rd_valid,
  input  wire        rd_ready,
  output reg         cmd_fwd,
  output reg  [7:0]  cmd_fwd_code,
  input  wire        fwd_done,
  input  wire        fwd_err,
  input  wire [1:0]  pwr_state,
  input  wire        dst_busy,
  input  wire        odc_busy,
  input  wire        sct_start,
  input  wire [15:0] sct_action,
  input  wire [15:0] sct_func,
  input  wire        sct_done,
  input  wire [15:0] sct_ext,
  input  wire        lba_write,
  input  wire        cap_change,
  input  wire        fill_all_ok,
  input  wire        nv_flag_in,
  output reg         nv_flag_we,
  output reg         nv_flag_out,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_we,
  input  wire        reg_re,
  output reg  [31:0] reg_rdata,
  output reg         irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_FWD  = 2'h1;
  localparam ST_XFER = 2'h2;

  reg  [1:0]  st_r;
  reg  [7:0]  feat_r;
  reg  [7:0]  cnt_r;
  reg  [7:0]  cnt_prev_r;
  reg  [7:0]  lbalo_r;
  reg  [7:0]  mid_r;
  reg  [7:0]  mid_prev_r;
  reg  [7:0]  hi_r;
  reg  [7:0]  dev_r;
  reg  [7:0]  idx_r;
  reg  [8:0]  nwd_r;
  reg         loaded_r;
  reg         seg_r;
  reg  [15:0] ver_r;
  reg  [15:0] ext_r;
  reg  [15:0] act_r;
  reg  [15:0] fnc_r;
  reg  [`SSR_NIRQ-1:0] ist_r;
  reg  [`SSR_NIRQ-1:0] imask_r;
  reg  [`SSR_NIRQ-1:0] ev_nxt;
  reg  [`SSR_NIRQ-1:0] ist_nxt;
  reg  [7:0]  drv_nxt;
  reg         seg_nxt;
  reg         serve_ev;
  reg         abrt_ev;
  reg         clr_ev;
  wire [15:0] pg_word;
  wire        cmd_wr;
  wire        ours;
  wire        is_smart;
  wire        is_logx;
  wire        smart_ok;
  wire        logx_ok;
  wire        sct_busy;
  wire        take;

  // a command write aimed at this drive
  assign cmd_wr = tf_we & (tf_addr == `SSR_TF_CMD);
  assign ours   = (dev_r[`SSR_DEV_BIT] == `SSR_DEV_NUM);

  // smart route opcode and log address
  assign is_smart = (tf_wdata == `SSR_CMD_SMART) &
                    (feat_r == `SSR_SM_RDLOG) &
                    (lbalo_r == `SSR_LOG_STAT);
  assign smart_ok = (cnt_r == `SSR_ONE_SECT) &
                    (mid_r == `SSR_SIG_LO) &
                    (hi_r == `SSR_SIG_HI);

  // extended log route opcode and address
  assign is_logx = (tf_wdata == `SSR_CMD_RLOGX) &
                   (lbalo_r == `SSR_LOG_STAT);
  // 16-bit count of one, zero mid
  assign logx_ok = (cnt_r == `SSR_ONE_SECT) &
                   (cnt_prev_r == `SSR_ZERO8) &
                   (mid_r == `SSR_ZERO8) &
                   (mid_prev_r == `SSR_ZERO8);

  assign sct_busy = (ext_r == `SSR_EXT_BUSY);
  assign take     = ~rd_valid | rd_ready;

  // page word generator
  ssr_page_word u_page (
    .idx      (idx_r),
    .ver      (ver_r),
    .seg_flag (seg_r),
    .drv_stat (drv_nxt),
    .ext_stat (ext_r),
    .act_code (act_r),
    .fnc_code (fnc_r),
    .word     (pg_word)
  );

  // drive activity, background work before power state
  always @* begin
    drv_nxt = `SSR_DS_IDLE;
    if (sct_busy) begin
      drv_nxt = `SSR_DS_SCT;
    end else if (odc_busy) begin
      drv_nxt = `SSR_DS_ODC;
    end else if (dst_busy) begin
      drv_nxt = `SSR_DS_DST;
    end else if (pwr_state == `SSR_PW_SLEEP) begin
      drv_nxt = `SSR_DS_SLEEP;
    end else if (pwr_state == `SSR_PW_STBY) begin
      drv_nxt = `SSR_DS_STBY;
    end
  end

  // segment flag next value; a later write cancels a fill
  always @* begin
    seg_nxt = seg_r;
    clr_ev  = 1'b0;
    if (fill_all_ok) begin
      seg_nxt = 1'b1;
    end
    if (lba_write | cap_change) begin
      seg_nxt = 1'b0;
      clr_ev  = seg_r | fill_all_ok;
    end
  end

  // shadow taskfile registers, previous bytes for 48-bit use
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      feat_r     <= 8'h00;
      cnt_r      <= 8'h00;
      cnt_prev_r <= 8'h00;
      lbalo_r    <= 8'h00;
      mid_r      <= 8'h00;
      mid_prev_r <= 8'h00;
      hi_r       <= 8'h00;
      dev_r      <= 8'h00;
    end else if (tf_we && st_r == ST_IDLE) begin
      case (tf_addr)
        `SSR_TF_FEAT:   feat_r <= tf_wdata;
        `SSR_TF_CNT: begin
          cnt_prev_r <= cnt_r;
          cnt_r      <= tf_wdata;
        end
        `SSR_TF_LBALO:  lbalo_r <= tf_wdata;
        `SSR_TF_LBAMID: begin
          mid_prev_r <= mid_r;
          mid_r      <= tf_wdata;
        end
        `SSR_TF_LBAHI:  hi_r <= tf_wdata;
        `SSR_TF_DEV:    dev_r <= tf_wdata;
        default:        feat_r <= feat_r;
      endcase
    end
  end

  // command sequencer: forward, abort, or stream the page
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r         <= ST_IDLE;
      tf_status    <= `SSR_ST_BUSY;
      tf_error     <= 8'h00;
      rd_word      <= 16'h0000;
      rd_valid     <= 1'b0;
      cmd_fwd      <= 1'b0;
      cmd_fwd_code <= 8'h00;
      idx_r        <= 8'h00;
      nwd_r        <= 9'h000;
      serve_ev     <= 1'b0;
      abrt_ev      <= 1'b0;
    end else begin
      cmd_fwd  <= 1'b0;
      serve_ev <= 1'b0;
      abrt_ev  <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          // ready only once the saved flag is restored
          if (!loaded_r) begin
            tf_status <= `SSR_ST_BUSY;
          end else if (tf_status == `SSR_ST_BUSY) begin
            tf_status <= `SSR_ST_READY;
          end else if (cmd_wr && ours) begin
            tf_error <= 8'h00;
            // no power or abort side effects
            if ((is_smart && smart_ok) || (is_logx && logx_ok)) begin
              st_r      <= ST_XFER;
              tf_status <= `SSR_ST_DRQ;
              idx_r     <= 8'h00;
              nwd_r     <= 9'h000;
            end else if (is_smart || is_logx) begin
              tf_status <= `SSR_ST_ERR;
              tf_error  <= `SSR_ERR_ABRT;
              abrt_ev   <= 1'b1;
            end else begin
              st_r         <= ST_FWD;
              tf_status    <= `SSR_ST_BUSY;
              cmd_fwd      <= 1'b1;
              cmd_fwd_code <= tf_wdata;
            end
          end
        end
        ST_FWD: begin
          if (fwd_done) begin
            st_r <= ST_IDLE;
            if (fwd_err) begin
              tf_status <= `SSR_ST_ERR;
              tf_error  <= `SSR_ERR_ABRT;
              abrt_ev   <= 1'b1;
            end else begin
              tf_status <= `SSR_ST_READY;
            end
          end
        end
        ST_XFER: begin
          if (take) begin
            if (nwd_r != `SSR_PAGE_WDS) begin
              rd_word  <= pg_word;
              rd_valid <= 1'b1;
              idx_r    <= idx_r + 8'h01;
              nwd_r    <= nwd_r + 9'h001;
            end else begin
              rd_valid  <= 1'b0;
              st_r      <= ST_IDLE;
              tf_status <= `SSR_ST_READY;
              serve_ev  <= 1'b1;
            end
          end
        end
        default: begin
          st_r      <= ST_IDLE;
          rd_valid  <= 1'b0;
          tf_status <= `SSR_ST_READY;
        end
      endcase
    end
  end

  // flag restored from storage after reset release
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      loaded_r    <= 1'b0;
      seg_r       <= 1'b0;
      nv_flag_we  <= 1'b0;
      nv_flag_out <= 1'b0;
    end else if (!loaded_r) begin
      loaded_r    <= 1'b1;
      seg_r       <= nv_flag_in;
      nv_flag_out <= nv_flag_in;
      nv_flag_we  <= 1'b0;
    end else begin
      seg_r       <= seg_nxt;
      nv_flag_we  <= (seg_nxt != seg_r);
      nv_flag_out <= seg_nxt;
    end
  end

  // last transport command bookkeeping
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_r <= 16'h0000;
      act_r <= 16'h0000;
      fnc_r <= 16'h0000;
    end else if (sct_start) begin
      ext_r <= `SSR_EXT_BUSY;
      act_r <= sct_action;
      fnc_r <= sct_func;
    end else if (sct_done && sct_busy) begin
      ext_r <= sct_ext;
    end
  end

  // sticky events, set wins over a write-one clear
  always @* begin
    ev_nxt = {`SSR_NIRQ{1'b0}};
    ev_nxt[`SSR_IRQ_SERV] = serve_ev;
    ev_nxt[`SSR_IRQ_DONE] = sct_done & sct_busy & ~sct_start;
    ev_nxt[`SSR_IRQ_CLR]  = clr_ev & loaded_r;
    ev_nxt[`SSR_IRQ_ABRT] = abrt_ev;
    ist_nxt = ist_r;
    if (reg_we && reg_addr == `SSR_RA_ISTAT) begin
      ist_nxt = ist_r & ~reg_wdata[`SSR_NIRQ-1:0];
    end
    ist_nxt = ist_nxt | ev_nxt;
  end

  // software registers and interrupt line
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ist_r     <= {`SSR_NIRQ{1'b0}};
      imask_r   <= {`SSR_NIRQ{1'b0}};
      ver_r     <= `SSR_VER_RST;
      reg_rdata <= 32'h00000000;
      irq       <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      irq   <= |(ist_nxt & imask_r);
      if (reg_we && reg_addr == `SSR_RA_IMASK) begin
        imask_r <= reg_wdata[`SSR_NIRQ-1:0];
      end
      if (reg_we && reg_addr == `SSR_RA_VER) begin
        ver_r <= reg_wdata[15:0];
      end
      reg_rdata <= 32'h00000000;
      if (reg_re) begin
        case (reg_addr)
          `SSR_RA_ISTAT: reg_rdata <= {28'h0000000, ist_r};
          `SSR_RA_IMASK: reg_rdata <= {28'h0000000, imask_r};
          `SSR_RA_VER:   reg_rdata <= {16'h0000, ver_r};
          `SSR_RA_STATE: reg_rdata <= {ext_r, drv_nxt, 4'h0, st_r, sct_busy, seg_r};
          default:       reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ==== core/ssr_map.vh ====
// Behaviour
// - taskfile status shows only accept or reject of a long command, never its outcome.
// - status information lives in log page e0 and is returned on each read.
// - status read accepted any idle time; no power change, no abort of background work.
// - bytes 1:0 hold format version 0003.
// - bytes 5:4 hold spec level 0001; bytes 3:2 hold a vendor version.
// - flag bit 0 set after fill of all sectors without error; bits 1-31 zero.
// - segment flag cleared on any user sector write, cache or not.
// - segment flag cleared on capacity change by set-max or overlay.
// - segment flag survives power loss.
// - byte 10 gives activity: idle, standby, sleep, self-test, data collection, transport.
// - bytes 15:14 last completion status, ffff while running.
// - bytes 17:16 action code of last or running command.
// - bytes 19:18 function code of last or running command.
`ifndef SSR_MAP_VH
`define SSR_MAP_VH
// taskfile register addresses
`define SSR_TF_FEAT   3'h1
`define SSR_TF_CNT    3'h2
`define SSR_TF_LBALO  3'h3
`define SSR_TF_LBAMID 3'h4
`define SSR_TF_LBAHI  3'h5
`define SSR_TF_DEV    3'h6
`define SSR_TF_CMD    3'h7
`define SSR_DEV_BIT   4
`define SSR_DEV_NUM   1'b0
// command codes and signatures
`define SSR_CMD_SMART 8'hb0
`define SSR_CMD_RLOGX 8'h2f
`define SSR_SM_RDLOG  8'hd5
`define SSR_LOG_STAT  8'he0
`define SSR_SIG_LO    8'h4f
`define SSR_SIG_HI    8'hc2
`define SSR_ONE_SECT  8'h01
`define SSR_ZERO8     8'h00
// taskfile status and error values
`define SSR_ST_BUSY   8'h80
`define SSR_ST_READY  8'h40
`define SSR_ST_DRQ    8'h48
`define SSR_ST_ERR    8'h41
`define SSR_ERR_ABRT  8'h04
// page content
`define SSR_FMT_VER   16'h0003
`define SSR_SPEC_LVL  16'h0001
`define SSR_EXT_BUSY  16'hffff
`define SSR_VER_RST   16'h0000
`define SSR_W_FMT     8'h00
`define SSR_W_VER     8'h01
`define SSR_W_SPEC    8'h02
`define SSR_W_FLAGLO  8'h03
`define SSR_W_ACT     8'h05
`define SSR_W_EXT     8'h07
`define SSR_W_ACODE   8'h08
`define SSR_W_FCODE   8'h09
`define SSR_PAGE_WDS  9'h100
// activity codes
`define SSR_DS_IDLE   8'h00
`define SSR_DS_STBY   8'h01
`define SSR_DS_SLEEP  8'h02
`define SSR_DS_DST    8'h03
`define SSR_DS_ODC    8'h04
`define SSR_DS_SCT    8'h05
`define SSR_PW_STBY   2'h1
`define SSR_PW_SLEEP  2'h2
// software register map and interrupt bits
`define SSR_RA_ISTAT  4'h0
`define SSR_RA_IMASK  4'h1
`define SSR_RA_VER    4'h2
`define SSR_RA_STATE  4'h3
`define SSR_NIRQ      4
`define SSR_IRQ_SERV  0
`define SSR_IRQ_DONE  1
`define SSR_IRQ_CLR   2
`define SSR_IRQ_ABRT  3
`endif

// ==== core/ssr_page_word.v ====
`include "ssr_map.vh"
// one 16-bit word of the status sector, picked by its index
module ssr_page_word (
  input  wire [7:0]  idx,
  input  wire [15:0] ver,
  input  wire        seg_flag,
  input  wire [7:0]  drv_stat,
  input  wire [15:0] ext_stat,
  input  wire [15:0] act_code,
  input  wire [15:0] fnc_code,
  output reg  [15:0] word
);

  // even byte sits in the low half of each word
  always @* begin
    word = 16'h0000;
    case (idx)
      `SSR_W_FMT:    word = `SSR_FMT_VER;
      `SSR_W_VER:    word = ver;
      `SSR_W_SPEC:   word = `SSR_SPEC_LVL;
      `SSR_W_FLAGLO: word = {15'h0, seg_flag};
      `SSR_W_ACT:    word = {8'h00, drv_stat};
      `SSR_W_EXT:    word = ext_stat;
      `SSR_W_ACODE:  word = act_code;
      `SSR_W_FCODE:  word = fnc_code;
      default:       word = 16'h0000;
    endcase
  end

endmodule

// ==== tb/ssr_status_log_asserts.sv ====
module ssr_chk (
  input wire        clk_sys,
  input wire        resetn,
  input wire        tf_we,
  input wire [2:0]  tf_addr,
  input wire [7:0]  tf_wdata,
  input wire [7:0]  tf_status,
  input wire [7:0]  tf_error,
  input wire [15:0] rd_word,
  input wire        rd_valid,
  input wire        rd_ready,
  input wire        cmd_fwd,
  input wire        fwd_done,
  input wire        sct_done,
  input wire        lba_write,
  input wire        cap_change,
  input wire        fill_all_ok,
  input wire        nv_flag_we,
  input wire        nv_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // page streaming
  AST_PAGE_START: assert property ($rose(tf_status == 8'h48) |=> rd_valid)
    else $error("status page not offered");
  AST_WORD0: assert property ($rose(rd_valid) |-> rd_word == 16'h0003)
    else $error("first word not format version");
  AST_HOLD: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_word))
    else $error("word dropped before taken");
  // forwarded commands go busy until forward done; background done leaves status alone
  AST_FWD_STAT: assert property (cmd_fwd |-> tf_status == 8'h80)
    else $error("forward without busy");
  AST_FWD_CAUSE: assert property (tf_we && tf_addr == 3'h7 && tf_wdata == 8'hec &&
    (tf_status == 8'h40 || tf_status == 8'h41) |=> cmd_fwd)
    else $error("other command not forwarded");
  AST_DONE_KEEP: assert property (sct_done && !fwd_done && !rd_valid && !tf_we |=> $stable(tf_status))
    else $error("background done moved taskfile status");
  AST_ERR: assert property (tf_status == 8'h41 |-> tf_error == 8'h04)
    else $error("error status without abort code");
  // segment flag storage updates
  AST_CLR: assert property ((lba_write || cap_change) && nv_flag_out |-> ##[1:2] nv_flag_we && !nv_flag_out)
    else $error("flag not cleared in storage");
  AST_SET: assert property (fill_all_ok && !lba_write && !cap_change && !nv_flag_out |-> ##[1:2] nv_flag_we && nv_flag_out)
    else $error("flag not set in storage");
  cover property (rd_valid && rd_ready && rd_word == 16'h0003);
  cover property (cmd_fwd);
  cover property (nv_flag_we && !nv_flag_out);
endmodule
bind ssr_status_log ssr_chk u_chk (.*);

// ==== tb/ssr_host_model.sv ====
module ssr_host_model (
  input  wire        clk_sys,
  input  wire        stall,
  output logic       tf_we,
  output logic [2:0] tf_addr,
  output logic [7:0] tf_wdata,
  output logic       rd_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tf_we = 1'b0;
    tf_addr = 3'h0;
    tf_wdata = 8'h00;
    rd_ready = 1'b0;
  end
  // one register write, strobe kept up between writes
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    tf_addr <= a;
    tf_wdata <= d;
    tf_we <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [7:0] op, f, c, l, m, h);
    wr(3'h1, f);
    wr(3'h2, 8'h00);
    wr(3'h2, c);
    wr(3'h3, l);
    wr(3'h4, 8'h00);
    wr(3'h4, m);
    wr(3'h5, h);
    wr(3'h6, 8'h00);
    wr(3'h7, op);
    tf_we <= 1'b0;
  endtask
  // word sink, stalls at random when asked
  always @(posedge clk_sys)
    rd_ready <= stall ? ($urandom % 3 != 0) : 1'b1;
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, resetn = 1'b0, stall = 1'b0, fwd_done = 1'b0, fwd_err = 1'b0;
  logic        dst_busy = 1'b0, odc_busy = 1'b0, sct_start = 1'b0, sct_done = 1'b0, lba_write = 1'b0;
  logic        cap_change = 1'b0, fill_all_ok = 1'b0, nv_flag_in = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
  logic        re_d = 1'b0, flag_e = 1'b0;
  logic [1:0]  pwr_state = 2'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  act_e;
  logic [15:0] sct_action = 16'h0000, sct_func = 16'h0000, sct_ext = 16'h0000, ver_e, ext_e;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [63:0] e;
  logic [15:0] wq[$];
  logic [63:0] rq[$];
  wire         tf_we, rd_valid, rd_ready, cmd_fwd, nv_flag_we, nv_flag_out, irq;
  wire  [2:0]  tf_addr;
  wire  [7:0]  tf_wdata, tf_status, tf_error, cmd_fwd_code;
  wire  [15:0] rd_word;
  wire  [31:0] reg_rdata;
  int          failures = 0, comparisons = 0;
  ssr_host_model host (.*);
  ssr_status_log uut (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string m, input logic [31:0] g, x);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, x);
    end
  endtask
  // pops the oldest note whenever a word is taken (valid and ready) or a read result shows
  always @(posedge clk_sys) begin
    re_d <= reg_re;
    // a word with no note left can never match
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      cmp("page word", 32'(rd_word), wq.size() > 0 ? 32'(wq.pop_front()) : 32'h00010000);
    if (re_d === 1'b1) begin
      e = rq.pop_front();
      cmp("reg read", reg_rdata & e[63:32], e[31:0]);
    end
  end
  // storage of the saved flag across a power cycle
  always @(posedge clk_sys)
    if (nv_flag_we === 1'b1)
      nv_flag_in <= nv_flag_out;
  task automatic wait_st(input logic [7:0] s);
    int n;
    n = 0;
    while (tf_status !== s) begin
      @(posedge clk_sys);
      if (++n > 3000) begin
        failures++;
        final_report();
      end
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] m, x);
    rq.push_back({m, x});
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    @(posedge clk_sys);
  endtask
  // one pulse: 5 fill, 4 write, 3 capacity, 2 start, 1 done, 0 forward done
  task automatic ev(input int k);
    {fill_all_ok, lba_write, cap_change, sct_start, sct_done, fwd_done} <= 6'h01 << k;
    @(posedge clk_sys);
    {fill_all_ok, lba_write, cap_change, sct_start, sct_done, fwd_done} <= 6'h00;
    @(posedge clk_sys);
  endtask
  // issue a command, note the expected page, check taskfile status
  task automatic page(input logic [7:0] op, c, l, m, st);
    if (st == 8'h48)
      for (int i = 0; i < 256; i++)
        wq.push_back(i == 0 ? 16'h0003 : i == 1 ? ver_e : i == 2 ? 16'h0001 : i == 3 ? {15'h0, flag_e} :
          i == 5 ? {8'h00, act_e} : i == 7 ? ext_e : i == 8 ? sct_action : i == 9 ? sct_func : 16'h0000);
    host.cmd(op, 8'hd5, c, l, m, 8'hc2);
    @(posedge clk_sys);
    cmp("taskfile status", 32'(tf_status), 32'(st));
    if (st == 8'h41)
      cmp("taskfile error", 32'(tf_error), 32'h04);
    wait_st(st == 8'h48 ? 8'h40 : st);
    cmp("words left", 32'(wq.size()), 0);
  endtask
  // masked, then unmasked, then cleared
  task automatic irq_chk(input int b);
    cmp("irq", 32'(irq), 0);
    wreg(4'h1, 32'h1 << b);
    @(posedge clk_sys);
    cmp("irq", 32'(irq), 1);
    wreg(4'h0, 32'hf);
    @(posedge clk_sys);
    cmp("irq", 32'(irq), 0);
    wreg(4'h1, 0);
  endtask
  initial begin
    void'($urandom(32'h09ca61d9));
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    wait_st(8'h40);
    rreg(4'h2, 32'hffff, 0);
    ver_e = 16'($urandom);
    wreg(4'h2, {16'h0, ver_e});
    wreg(4'he, 32'hffffffff);
    rreg(4'he, 32'hffffffff, 0);
    rreg(4'h2, 32'hffff, {16'h0, ver_e});
    sct_action <= 16'($urandom);
    sct_func <= 16'($urandom);
    for (int k = 0; k < 6; k++) begin
      pwr_state <= k == 1 ? 2'h1 : k == 2 ? 2'h2 : 2'h0;
      dst_busy <= k == 3;
      odc_busy <= k == 4;
      ev(k == 5 ? 2 : 6);
      rreg(4'h3, 32'h0000ff00, k << 8);
    end
    $display("test activity done");
    act_e = 8'h05;
    ext_e = 16'hffff;
    stall <= 1'b1;
    page(8'hb0, 8'h01, 8'he0, 8'h4f, 8'h48);
    rreg(4'h3, 32'hffff0002, 32'hffff0002);
    rreg(4'h0, 32'h1, 32'h1);
    irq_chk(0);
    $display("test smart page done");
    ev(5);
    flag_e = 1'b1;
    sct_ext <= 16'($urandom % 32'hffff);
    ev(1);
    ext_e = sct_ext;
    dst_busy <= 1'b1;
    act_e = 8'h03;
    page(8'h2f, 8'h01, 8'he0, 8'h00, 8'h48);
    rreg(4'h0, 32'h2, 32'h2);
    $display("test log page done");
    page(8'h2f, 8'h02, 8'he0, 8'h00, 8'h41);
    page(8'hb0, 8'h01, 8'he0, 8'h00, 8'h41);
    irq_chk(3);
    $display("test abort done");
    page(8'hec, 8'h01, 8'h00, 8'h00, 8'h80);
    cmp("forward code", 32'(cmd_fwd_code), 32'hec);
    fwd_err <= 1'b1;
    ev(0);
    cmp("taskfile status", 32'(tf_status), 32'h41);
    fwd_err <= 1'b0;
    page(8'hec, 8'h01, 8'h00, 8'h00, 8'h80);
    ev(0);
    cmp("taskfile status", 32'(tf_status), 32'h40);
    $display("test forward done");
    ev(4);
    rreg(4'h3, 32'h1, 32'h0);
    rreg(4'h0, 32'h4, 32'h4);
    ev(5);
    rreg(4'h3, 32'h1, 32'h1);
    ev(3);
    rreg(4'h3, 32'h1, 32'h0);
    $display("test flag done");
    ev(5);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    wait_st(8'h40);
    rreg(4'h3, 32'h1, 32'h1);
    $display("test power cycle done");
    final_report();
  end
endmodule
